// [core/ulb_dev.sv]
// ulb_dev: asynchronous serial port with auto-baud, wake on break and break send.
// assumes lines synchronous to i_clk; register port is a simple one-cycle strobe port.
`timescale 1ns/1ps
module ulb_dev
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // serial lines
  ulb_if.dev              lin,
  // register port
  input  wire logic [2:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // power state and events
  input  wire logic       i_sleep,
  output logic            o_rx_pending,
  output logic            o_wake
);
  ulb_pkg::ulb_rx_t rx_st_r, st_nxt;
  logic [15:0] div_r, div_nxt, rx_tmr_r, tmr_nxt, tx_tmr_r;
  logic [13:0] tsr_r;
  logic [7:0]  rx_sh_r, sh_nxt, rxdata_r, txbuf_r, rd_mux;
  logic [3:0]  rx_bits_r, bits_nxt, tx_bits_r;
  logic [2:0]  abd_pre_r, abd_edges_r;
  logic        ovf_r, autobaud_enable_r, wue_r, transmit_enable_r, sync_r, send_break_request_r, pend_r, framing_error_flag_r;
  logic        txbuf_full_r, tx_busy_r, tx_brk_r, rx_prev_r;
  logic        rx_done, wake_fall, wake_rise, abd_go, abd_inc, abd_done;

  // register decode
  wire wr_baud = i_wr & (i_addr == ulb_pkg::REG_BAUD_CTRL);
  wire wr_txs  = i_wr & (i_addr == ulb_pkg::REG_TX_STAT);
  wire wr_txd  = i_wr & (i_addr == ulb_pkg::REG_TX_DATA);
  wire wr_dlo  = i_wr & (i_addr == ulb_pkg::REG_DIV_LO);
  wire wr_dhi  = i_wr & (i_addr == ulb_pkg::REG_DIV_HI);
  wire rd_rx   = i_rd & (i_addr == ulb_pkg::REG_RX_DATA);

  // line edges and stepping; the wake watcher alone runs while asleep
  wire rx_in     = lin.rx_data_pin;
  wire rx_fall   = rx_prev_r & ~rx_in;
  wire rx_rise   = ~rx_prev_r & rx_in;
  wire run       = ~i_sleep;
  wire wue_eff   = wue_r & ~sync_r;
  wire wake_mode = (rx_st_r == ulb_pkg::RX_WAKE) | ((rx_st_r == ulb_pkg::RX_IDLE) & wue_eff);
  wire step      = run | wake_mode;
  wire rx_tick   = (rx_tmr_r == 16'h0000);
  wire pend_set  = step & (rx_done | abd_done | wake_fall);
  wire ovf_set   = step & abd_inc & ~abd_done & (div_r == 16'hFFFF);

  // transmitter control terms
  wire tx_tick = (tx_tmr_r == 16'h0000);
  wire tx_load = run & ~tx_busy_r & txbuf_full_r & transmit_enable_r;
  wire tx_adv  = run & tx_busy_r & tx_tick;
  wire tx_end  = tx_adv & (tx_bits_r == 4'h1);

  // receiver, auto-baud and wake sequencing
  always_comb
  begin
    st_nxt    = rx_st_r;
    tmr_nxt   = rx_tick ? div_r : rx_tmr_r - 16'h0001;
    bits_nxt  = rx_bits_r;
    sh_nxt    = rx_sh_r;
    rx_done   = 1'b0;
    wake_fall = 1'b0;
    wake_rise = 1'b0;
    abd_go    = 1'b0;
    abd_inc   = 1'b0;
    abd_done  = 1'b0;
    case (rx_st_r)
      ulb_pkg::RX_IDLE:
        if (wue_eff)
          st_nxt = ulb_pkg::RX_WAKE;
        else if (autobaud_enable_r)
          st_nxt = ulb_pkg::RX_ABDW;
        else if (rx_fall)
        begin
          st_nxt  = ulb_pkg::RX_START;
          tmr_nxt = div_r >> 1;                                // sample mid bit
        end
      ulb_pkg::RX_WAKE:
        if (!wue_eff)
          st_nxt = ulb_pkg::RX_IDLE;
        else
        begin
          wake_fall = rx_fall;
          if (rx_rise)
          begin
            wake_rise = 1'b1;
            st_nxt    = ulb_pkg::RX_IDLE;
          end
        end
      ulb_pkg::RX_START:
        if (rx_tick)
        begin
          st_nxt   = rx_in ? ulb_pkg::RX_IDLE : ulb_pkg::RX_DATA; // glitch rejected
          bits_nxt = 4'h0;
        end
      ulb_pkg::RX_DATA:
        if (rx_tick)
        begin
          sh_nxt   = {rx_in, rx_sh_r[7:1]};
          bits_nxt = rx_bits_r + 4'h1;
          if (rx_bits_r == 4'h7)
            st_nxt = ulb_pkg::RX_STOP;
        end
      ulb_pkg::RX_STOP:
        if (rx_tick)
        begin
          rx_done = 1'b1;
          st_nxt  = ulb_pkg::RX_IDLE;
        end
      ulb_pkg::RX_ABDW:
        if (!autobaud_enable_r)
          st_nxt = ulb_pkg::RX_IDLE;
        else if (rx_rise)
        begin
          abd_go = 1'b1;
          st_nxt = ulb_pkg::RX_ABDC;
        end
      ulb_pkg::RX_ABDC:
        if (!autobaud_enable_r)
          st_nxt = ulb_pkg::RX_IDLE;
        else
        begin
          abd_inc = (abd_pre_r == ulb_pkg::ABD_PRE_LAST);
          if (rx_rise && abd_edges_r == ulb_pkg::ABD_LAST_EDGE)
          begin
            abd_done = 1'b1;
            st_nxt   = ulb_pkg::RX_IDLE;
          end
        end
      default:
        st_nxt = ulb_pkg::RX_IDLE;
    endcase
  end

  // divisor pair doubles as the measurement counter; it wraps, never stops early
  always_comb
  begin
    div_nxt = div_r;
    if (step & abd_go)
      div_nxt = 16'h0001;
    else if (step & abd_inc & ~abd_done)
      div_nxt = div_r + 16'h0001;
    else if (wr_dlo)
      div_nxt = {div_r[15:8], i_wdata};
    else if (wr_dhi)
      div_nxt = {i_wdata, div_r[7:0]};
  end

  // receiver registers, frozen while asleep except for the wake watcher
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_st_r     <= ulb_pkg::RX_IDLE;
      rx_tmr_r    <= 16'h0000;
      rx_bits_r   <= 4'h0;
      rx_sh_r     <= 8'h00;
      abd_pre_r   <= 3'h0;
      abd_edges_r <= 3'h0;
    end
    else if (step)
    begin
      rx_st_r     <= st_nxt;
      rx_tmr_r    <= tmr_nxt;
      rx_bits_r   <= bits_nxt;
      rx_sh_r     <= sh_nxt;
      abd_pre_r   <= abd_go ? 3'h0 : abd_pre_r + 3'h1;
      abd_edges_r <= abd_go ? 3'h1 : abd_edges_r + {2'h0, rx_rise};
    end
  end

  // control and status flags; hardware set beats software clear
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_prev_r <= 1'b1;
      div_r     <= ulb_pkg::DIV_RST;
      ovf_r     <= 1'b0;
      autobaud_enable_r   <= 1'b0;
      wue_r     <= 1'b0;
      pend_r    <= 1'b0;
      framing_error_flag_r    <= 1'b0;
      rxdata_r  <= 8'h00;
    end
    else
    begin
      rx_prev_r <= rx_in;
      div_r     <= div_nxt;
      ovf_r     <= ovf_set | (ovf_r & ~(wr_baud & ~i_wdata[ulb_pkg::BC_OVF] & ~autobaud_enable_r));
      autobaud_enable_r   <= wr_baud ? i_wdata[ulb_pkg::BC_AUTOBAUD_ENABLE] : autobaud_enable_r & ~(step & abd_done);
      wue_r     <= wr_baud ? i_wdata[ulb_pkg::BC_WUE] : wue_r & ~(step & wake_rise);
      pend_r    <= pend_set | (pend_r & ~rd_rx);
      if (step & rx_done)
      begin
        rxdata_r <= rx_sh_r;
        framing_error_flag_r   <= ~rx_in;                                    // low stop bit
      end
    end
  end

  // transmit buffer, control bits and read data
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      transmit_enable_r       <= 1'b0;
      sync_r       <= 1'b0;
      send_break_request_r      <= 1'b0;
      txbuf_r      <= 8'h00;
      txbuf_full_r <= 1'b0;
      o_rdata      <= 8'h00;
    end
    else
    begin
      if (wr_txs)
      begin
        transmit_enable_r <= i_wdata[ulb_pkg::TS_TRANSMIT_ENABLE];
        sync_r <= i_wdata[ulb_pkg::TS_SYNC];
      end
      send_break_request_r      <= wr_txs ? i_wdata[ulb_pkg::TS_SEND_BREAK_REQUEST] : send_break_request_r & ~(tx_end & tx_brk_r);
      txbuf_full_r <= wr_txd | (txbuf_full_r & ~tx_load);      // preload allowed during break
      if (wr_txd)
        txbuf_r <= i_wdata;
      if (i_rd)
        o_rdata <= rd_mux;
    end
  end

  // shift register; idle fill is ones so the line rests high
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tsr_r     <= 14'h3FFF;
      tx_bits_r <= 4'h0;
      tx_busy_r <= 1'b0;
      tx_brk_r  <= 1'b0;
      tx_tmr_r  <= 16'h0000;
    end
    else if (tx_load)
    begin
      tsr_r     <= send_break_request_r ? ulb_pkg::BREAK_FRAME : {5'h1F, txbuf_r, 1'b0};
      tx_bits_r <= send_break_request_r ? ulb_pkg::BREAK_BITS : ulb_pkg::CHAR_BITS;
      tx_brk_r  <= send_break_request_r;
      tx_busy_r <= 1'b1;
      tx_tmr_r  <= div_r;
    end
    else if (tx_adv)
    begin
      tsr_r     <= {1'b1, tsr_r[13:1]};
      tx_bits_r <= tx_bits_r - 4'h1;
      tx_busy_r <= ~tx_end;                                    // next queued byte follows
      tx_tmr_r  <= div_r;
    end
    else if (run & tx_busy_r)
      tx_tmr_r <= tx_tmr_r - 16'h0001;
  end

  // read selection and outputs
  always_comb
  begin
    case (i_addr)
      ulb_pkg::REG_BAUD_CTRL: rd_mux = {ovf_r, rx_st_r == ulb_pkg::RX_IDLE, 4'h0, wue_r, autobaud_enable_r};
      ulb_pkg::REG_TX_STAT:   rd_mux = {2'h0, transmit_enable_r, sync_r, send_break_request_r, 1'b0, ~tx_busy_r, 1'b0};
      ulb_pkg::REG_RX_STAT:   rd_mux = {5'h00, framing_error_flag_r, ~txbuf_full_r, pend_r};
      ulb_pkg::REG_RX_DATA:   rd_mux = rxdata_r;
      ulb_pkg::REG_DIV_LO:    rd_mux = div_r[7:0];
      ulb_pkg::REG_DIV_HI:    rd_mux = div_r[15:8];
      default:                rd_mux = 8'h00;
    endcase
  end

  assign lin.tx_line  = tsr_r[0];
  assign o_rx_pending = pend_r;
  assign o_wake       = pend_r | (i_sleep & wue_eff & ~rx_in);
endmodule // ulb_dev

// [core/ulb_pkg.sv]
// ulb_pkg: constants shared by the serial port end and the line node end.
// assumes one 10 MHz system clock; register offsets and the serial port's bit positions live here, node control and status bits are coded in ulb_node.
package ulb_pkg;
  // clock and line rate
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          LIN_BAUD      = 19_200;
  localparam logic [15:0] NODE_BIT_CLKS = 16'(CLK_HZ / LIN_BAUD - 1);
  localparam logic [15:0] DIV_RST       = 16'h0040;
  // serial port register index
  localparam logic [2:0] REG_BAUD_CTRL = 3'h0;
  localparam logic [2:0] REG_TX_STAT   = 3'h1;
  localparam logic [2:0] REG_RX_STAT   = 3'h2;
  localparam logic [2:0] REG_RX_DATA   = 3'h3;
  localparam logic [2:0] REG_TX_DATA   = 3'h4;
  localparam logic [2:0] REG_DIV_LO    = 3'h5;
  localparam logic [2:0] REG_DIV_HI    = 3'h6;
  // bit positions
  localparam int BC_OVF = 7, BC_RECEIVE_IDLE_FLAG = 6, BC_WUE = 1, BC_AUTOBAUD_ENABLE = 0;
  localparam int TS_TRANSMIT_ENABLE = 5, TS_SYNC = 4, TS_SEND_BREAK_REQUEST = 3, TS_TRANSMIT_SHIFT_EMPTY = 1;
  localparam int RS_FRAMING_ERROR_FLAG = 2, RS_TRANSMIT_BUFFER_EMPTY_FLAG = 1, RS_PEND = 0;
  // auto-baud and frame shapes
  localparam logic [2:0]  ABD_PRE_LAST  = 3'h7;
  localparam logic [2:0]  ABD_LAST_EDGE = 3'h4;
  localparam int          BREAK_ZEROS   = 12;
  localparam logic [3:0]  CHAR_BITS     = 4'hA;
  localparam logic [3:0]  BREAK_BITS    = 4'(BREAK_ZEROS + 2);
  localparam logic [13:0] BREAK_FRAME   = 14'h2000;
  // node registers (byte addresses)
  localparam logic [7:0] N_CTRL = 8'h00, N_TXDATA = 8'h04, N_BRKLEN = 8'h08;
  localparam logic [7:0] N_BITCLK = 8'h0C, N_STATUS = 8'h10, N_RXDATA = 8'h14;
  localparam logic [4:0] WAKE_MIN_BITS = 5'h0A;
  localparam logic [4:0] LIN_BREAK_LEN = 5'h0D;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
  // receiver states, gray along idle-start-data-stop
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011, RX_STOP = 3'b010,
    RX_ABDW = 3'b110, RX_ABDC  = 3'b111, RX_WAKE = 3'b101
  } ulb_rx_t;
endpackage

// [core/ulb_if.sv]
// ulb_if: the two serial lines between the serial port and the line node.
// assumes both ends run on the same clock; lines idle high.
`timescale 1ns/1ps
interface ulb_if;
  logic tx_line;     // serial port to node
  logic rx_data_pin; // node to serial port
  modport dev  (output tx_line, input rx_data_pin);
  modport node (input tx_line, output rx_data_pin);
endinterface // ulb_if

// [core/ulb_node.sv]
// ulb_node: line node at the far end; sends characters and wake breaks, receives bytes.
// assumes an AXI4-Lite master on the same clock; one write and one read at a time.
`timescale 1ns/1ps
module ulb_node
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // serial lines
  ulb_if.node              lin,
  // axi4-lite slave
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic      [1:0]  o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic      [31:0] o_rdata,
  output logic      [1:0]  o_rresp
);
  ulb_pkg::ulb_rx_t rx_st_r;
  logic [31:0] tsh_r, wd_r;
  logic [15:0] bitclk_r, tx_tmr_r, rx_tmr_r;
  logic [7:0]  aw_r, txd_r, rsh_r, rxd_r;
  logic [5:0]  tx_bits_r;
  logic [4:0]  brk_r;
  logic [3:0]  rbits_r;
  logic        aw_have_r, w_have_r, rxv_r, rxferr_r;

  // write decode once both halves are held
  wire       wr_go   = aw_have_r & w_have_r & ~o_bvalid;
  wire       wr_map  = (aw_r <= ulb_pkg::N_RXDATA) & (aw_r[1:0] == 2'h0);
  wire       rd_map  = (i_araddr <= ulb_pkg::N_RXDATA) & (i_araddr[1:0] == 2'h0);
  wire       ar_take = i_arvalid & o_arready;
  wire       go      = wr_go & (aw_r == ulb_pkg::N_CTRL) & wd_r[0] & (tx_bits_r == 6'h00);
  // a wake break shorter than the minimum is stretched to it
  wire [4:0] brk_len = (brk_r < ulb_pkg::WAKE_MIN_BITS) ? ulb_pkg::WAKE_MIN_BITS : brk_r;
  wire       tx_tick = (tx_tmr_r == 16'h0000);
  wire       rx_tick = (rx_tmr_r == 16'h0000);
  wire       rx_in   = lin.tx_line;

  // axi4-lite handshakes and register writes
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_r      <= 8'h00;
      wd_r      <= 32'h0000_0000;
      o_bvalid  <= 1'b0;
      o_bresp   <= ulb_pkg::RESP_OKAY;
      txd_r     <= 8'h00;
      brk_r     <= ulb_pkg::LIN_BREAK_LEN;
      bitclk_r  <= ulb_pkg::NODE_BIT_CLKS;
    end
    else
    begin
      if (i_awvalid & o_awready)
      begin
        aw_have_r <= 1'b1;
        aw_r      <= i_awaddr;
      end
      if (i_wvalid & o_wready)
      begin
        w_have_r <= 1'b1;
        wd_r     <= i_wdata;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= wr_map ? ulb_pkg::RESP_OKAY : ulb_pkg::RESP_SLVERR;
        if (aw_r == ulb_pkg::N_TXDATA && i_wstrb[0])
          txd_r <= wd_r[7:0];
        if (aw_r == ulb_pkg::N_BRKLEN && i_wstrb[0])
          brk_r <= wd_r[4:0];
        if (aw_r == ulb_pkg::N_BITCLK)
          bitclk_r <= wd_r[15:0];
      end
      else if (o_bvalid & i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // read channel; reading received data clears its valid flag
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= ulb_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      o_rvalid <= 1'b1;
      o_rresp  <= rd_map ? ulb_pkg::RESP_OKAY : ulb_pkg::RESP_SLVERR;
      case (i_araddr)
        ulb_pkg::N_TXDATA: o_rdata <= {24'h00_0000, txd_r};
        ulb_pkg::N_BRKLEN: o_rdata <= {27'h000_0000, brk_r};
        ulb_pkg::N_BITCLK: o_rdata <= {16'h0000, bitclk_r};
        ulb_pkg::N_STATUS: o_rdata <= {29'h0000_0000, rxferr_r, rxv_r, tx_bits_r != 6'h00};
        ulb_pkg::N_RXDATA: o_rdata <= {24'h00_0000, rxd_r};
        default:           o_rdata <= 32'h0000_0000;
      endcase
    end
    else if (o_rvalid & i_rready)
      o_rvalid <= 1'b0;
  end

  // sender: byte frame or all-zero wake break, one frame at a time
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tsh_r     <= 32'hFFFF_FFFF;
      tx_bits_r <= 6'h00;
      tx_tmr_r  <= 16'h0000;
    end
    else if (go)
    begin
      tsh_r     <= wd_r[1] ? (32'hFFFF_FFFF << brk_len) : {23'h7F_FFFF, txd_r, 1'b0};
      tx_bits_r <= wd_r[1] ? 6'(brk_len) + 6'h01 : 6'h0A;
      tx_tmr_r  <= bitclk_r;
    end
    else if (tx_bits_r != 6'h00)
    begin
      tx_tmr_r <= tx_tick ? bitclk_r : tx_tmr_r - 16'h0001;
      if (tx_tick)
      begin
        tsh_r     <= {1'b1, tsh_r[31:1]};
        tx_bits_r <= tx_bits_r - 6'h01;
      end
    end
  end

  // receiver of the serial port's characters, breaks show as zero with framing error
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_st_r  <= ulb_pkg::RX_IDLE;
      rx_tmr_r <= 16'h0000;
      rbits_r  <= 4'h0;
      rsh_r    <= 8'h00;
      rxd_r    <= 8'h00;
      rxv_r    <= 1'b0;
      rxferr_r <= 1'b0;
    end
    else
    begin
      rx_tmr_r <= rx_tick ? bitclk_r : rx_tmr_r - 16'h0001;
      if (ar_take && i_araddr == ulb_pkg::N_RXDATA)
        rxv_r <= 1'b0;
      case (rx_st_r)
        ulb_pkg::RX_IDLE:
          if (!rx_in)
          begin
            rx_st_r  <= ulb_pkg::RX_START;
            rx_tmr_r <= bitclk_r >> 1;
          end
        ulb_pkg::RX_START:
          if (rx_tick)
          begin
            rx_st_r <= rx_in ? ulb_pkg::RX_IDLE : ulb_pkg::RX_DATA;
            rbits_r <= 4'h0;
          end
        ulb_pkg::RX_DATA:
          if (rx_tick)
          begin
            rsh_r   <= {rx_in, rsh_r[7:1]};
            rbits_r <= rbits_r + 4'h1;
            if (rbits_r == 4'h7)
              rx_st_r <= ulb_pkg::RX_STOP;
          end
        ulb_pkg::RX_STOP:
          if (rx_tick)
          begin
            rxd_r    <= rsh_r;
            rxv_r    <= 1'b1;
            rxferr_r <= ~rx_in;
            rx_st_r  <= rx_in ? ulb_pkg::RX_IDLE : ulb_pkg::RX_WAKE;
          end
        ulb_pkg::RX_WAKE:
          if (rx_in)
            rx_st_r <= ulb_pkg::RX_IDLE;                      // wait out a long break
        default:
          rx_st_r <= ulb_pkg::RX_IDLE;
      endcase
    end
  end

  assign o_awready       = ~aw_have_r;
  assign o_wready        = ~w_have_r;
  assign o_arready       = ~o_rvalid;
  assign lin.rx_data_pin = tsh_r[0];
endmodule // ulb_node

// [bench/ulb_props.sv]
// ulb_props: line timing and pending/wake checks beside the port-node pair.
// assumes both ends at the reset bit time, one clock, lines idle high.
`timescale 1ns/1ps
module ulb_props
(
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  // lines
  input wire logic       tx_line,
  input wire logic       rx_data_pin,
  // serial port pins
  input wire logic       i_sleep,
  input wire logic       i_rd,
  input wire logic [2:0] i_addr,
  input wire logic       o_rx_pending,
  input wire logic       o_wake
);
  localparam int BIT = int'(ulb_pkg::DIV_RST) + 1;
  logic [15:0] tx_low_r;
  logic [15:0] rx_low_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // low-run counters; a run longer than any character marks a break
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_low_r <= 16'h0000;
      rx_low_r <= 16'h0000;
    end
    else
    begin
      tx_low_r <= tx_line ? 16'h0000 : tx_low_r + 16'h0001;
      rx_low_r <= rx_data_pin ? 16'h0000 : rx_low_r + 16'h0001;
    end
  end
  AST_TX_BREAK: assert property ($rose(tx_line) && tx_low_r > 16'(9 * BIT) |-> tx_low_r == 16'(13 * BIT))
    else $error("tx break low time wrong");
  AST_NODE_BREAK: assert property ($rose(rx_data_pin) && rx_low_r > 16'(9 * BIT) |-> rx_low_r == 16'(13 * BIT))
    else $error("node break low time wrong");
  AST_SLEEP_TX: assert property (i_sleep && $past(i_sleep) |-> $stable(tx_line))
    else $error("tx moved while asleep");
  AST_SLEEP_RX: assert property (i_sleep && !o_wake |=> !o_rx_pending)
    else $error("pending set while asleep");
  AST_WAKE_PEND: assert property (o_rx_pending |-> o_wake)
    else $error("wake low while pending");
  AST_WAKE_LINE: assert property (!o_rx_pending && rx_data_pin |-> !o_wake)
    else $error("wake without low line");
  AST_WAKE_SET: assert property (o_wake && !o_rx_pending && !rx_data_pin |-> ##[1:2] o_rx_pending)
    else $error("pending not set on wake");
  AST_PEND_CLR: assert property ($fell(o_rx_pending) |-> $past(i_rd) && $past(i_addr) == ulb_pkg::REG_RX_DATA)
    else $error("pending cleared without data read");
endmodule // ulb_props

// [bench/ulb_tb.sv]
// uart_lin_break_wake_logic_tb: serial port and node joined by their lines, driven over both register ports.
// assumes node bit clock set equal to the port's reset divisor so both ends agree on baud.
`timescale 1ns/1ps
module uart_lin_break_wake_logic_tb;
  typedef struct { logic [31:0] e; logic [31:0] m; } ulb_exp_t;
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_sleep = 0, rd_q = 0;
  logic [2:0] i_addr = 0;
  logic [7:0] i_wdata = 0, d_rdata, rv, awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rx_pending, o_wake;
  logic [31:0] wdata = 0, n_rdata, seed = 32'h0000_5209, rnd;
  int errors = 0, comparisons = 0, n;
  ulb_exp_t dq[$], nq[$];
  ulb_if lin ();
  ulb_dev u_ulb_dev (.i_clk(i_clk), .i_reset_n(i_reset_n), .lin(lin), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(d_rdata), .i_sleep(i_sleep), .o_rx_pending(o_rx_pending), .o_wake(o_wake));
  ulb_node u_ulb_node (.i_clk(i_clk), .i_reset_n(i_reset_n), .lin(lin), .i_awvalid(awvalid), .o_awready(o_awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(o_wready), .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(o_bvalid),
    .i_bready(bready), .o_bresp(), .i_arvalid(arvalid), .o_arready(o_arready), .i_araddr(araddr),
    .o_rvalid(o_rvalid), .i_rready(rready), .o_rdata(n_rdata), .o_rresp());
  ulb_props u_ulb_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .tx_line(lin.tx_line), .rx_data_pin(lin.rx_data_pin),
    .i_sleep(i_sleep), .i_rd(i_rd), .i_addr(i_addr), .o_rx_pending(o_rx_pending), .o_wake(o_wake));
  always #50 i_clk = ~i_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic fail(input string s);
    errors++;
    $display("[ERR] %s expected done seen timeout", s);
    tally_and_finish();
  endtask
  task automatic chk_dev(input ulb_exp_t x, input logic [7:0] v);
    comparisons++;
    if ((v & x.m[7:0]) !== (x.e[7:0] & x.m[7:0]))
    begin
      errors++;
      $display("[ERR] dev_rdata expected %h seen %h", x.e[7:0], v);
    end
  endtask
  task automatic chk_node(input ulb_exp_t x, input logic [31:0] v);
    comparisons++;
    if ((v & x.m) !== (x.e & x.m))
    begin
      errors++;
      $display("[ERR] node_rdata expected %h seen %h", x.e, v);
    end
  endtask
  // results are compared as they appear, oldest note first
  always @(posedge i_clk)
  begin
    rd_q <= i_rd;
    if (rd_q)
      chk_dev(dq.pop_front(), d_rdata);
    if (o_rvalid && rready)
      chk_node(nq.pop_front(), n_rdata);
  end
  task automatic dw(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  // data lands the cycle after the strobe is taken
  task automatic dr(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    dq.push_back('{32'(e), 32'(m)});
    @(posedge i_clk);
    i_rd <= 1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    @(posedge i_clk);
    rv = d_rdata;
  endtask
  // address and data offered together, bready held until the response
  task automatic nw(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 50 && !o_bvalid; k++)
    begin
      @(posedge i_clk);
      if (awvalid && o_awready) awvalid <= 0;
      if (wvalid && o_wready) wvalid <= 0;
    end
    bready <= 0;
    if (k == 50) fail("node_bvalid");
  endtask
  task automatic nr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    int k;
    nq.push_back('{e, m});
    @(posedge i_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 50 && !o_rvalid; k++)
    begin
      @(posedge i_clk);
      if (arvalid && o_arready) arvalid <= 0;
    end
    rv = n_rdata[7:0];
    rready <= 0;
    if (k == 50) fail("node_rvalid");
  endtask
  // bounded poll of a register field on either end
  task automatic poll(input bit nd, input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    int k;
    for (k = 0; k < 2000; k++)
    begin
      if (nd) nr(a, 0, 0); else dr(a[2:0], 0, 0);
      if ((rv & m) === v) break;
    end
    if (k == 2000) fail("poll");
  endtask
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1;
    nw(ulb_pkg::N_BITCLK, 32'(ulb_pkg::DIV_RST));
    // break with random dummy, then queued sync byte
    rnd = xs();
    dr(ulb_pkg::REG_RX_STAT, 8'h02, 8'h03);
    dw(ulb_pkg::REG_TX_STAT, 8'h28);
    dw(ulb_pkg::REG_TX_DATA, rnd[7:0]);
    dw(ulb_pkg::REG_TX_DATA, 8'h55);
    dr(ulb_pkg::REG_TX_STAT, 8'h08, 8'h0A);
    dr(ulb_pkg::REG_RX_STAT, 8'h00, 8'h02);
    poll(0, ulb_pkg::REG_TX_STAT, 8'h0A, 8'h02);
    nr(ulb_pkg::N_RXDATA, 32'h55, 32'hFF);
    // break received at matching baud
    nw(ulb_pkg::N_CTRL, 32'h3);
    poll(0, ulb_pkg::REG_RX_STAT, 8'h01, 8'h01);
    dr(ulb_pkg::REG_RX_STAT, 8'h05, 8'h05);
    dr(ulb_pkg::REG_RX_DATA, 8'h00, 8'hFF);
    // sync mode keeps the wake watcher off, so the receiver stays idle
    dw(ulb_pkg::REG_TX_STAT, 8'h10);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h02);
    dr(ulb_pkg::REG_BAUD_CTRL, 8'h42, 8'h42);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h00);
    dw(ulb_pkg::REG_TX_STAT, 8'h00);
    // wake on break from sleep with auto-baud armed, then sync and a random byte
    poll(1, ulb_pkg::N_STATUS, 8'h01, 8'h00);
    dr(ulb_pkg::REG_BAUD_CTRL, 8'h40, 8'h40);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h03);
    @(posedge i_clk) i_sleep <= 1;
    nw(ulb_pkg::N_CTRL, 32'h3);
    for (n = 0; n < 2000 && !o_wake; n++) @(posedge i_clk);
    if (n == 2000) fail("wake");
    i_sleep <= 0;
    poll(0, ulb_pkg::REG_BAUD_CTRL, 8'h02, 8'h00);
    dr(ulb_pkg::REG_BAUD_CTRL, 8'h01, 8'h01);
    dr(ulb_pkg::REG_RX_STAT, 8'h01, 8'h01);
    dr(ulb_pkg::REG_RX_DATA, 8'h00, 8'h00);
    dr(ulb_pkg::REG_RX_STAT, 8'h00, 8'h01);
    // auto-baud on the sync byte that follows the break, at the reset bit time
    poll(1, ulb_pkg::N_STATUS, 8'h01, 8'h00);
    nw(ulb_pkg::N_TXDATA, 32'h55);
    nw(ulb_pkg::N_CTRL, 32'h1);
    poll(0, ulb_pkg::REG_BAUD_CTRL, 8'h01, 8'h00);
    dr(ulb_pkg::REG_RX_STAT, 8'h01, 8'h01);
    dr(ulb_pkg::REG_DIV_HI, 8'h00, 8'hFF);
    dr(ulb_pkg::REG_DIV_LO, 8'h40, 8'hF0);
    dr(ulb_pkg::REG_BAUD_CTRL, 8'h00, 8'h80);
    // discard the measurement's pending data and put the divisor back on the node's rate
    dr(ulb_pkg::REG_RX_DATA, 8'h00, 8'h00);
    dw(ulb_pkg::REG_DIV_LO, 8'h40);
    poll(1, ulb_pkg::N_STATUS, 8'h01, 8'h00);
    rnd = xs();
    nw(ulb_pkg::N_TXDATA, {24'h0, rnd[7:0]});
    nw(ulb_pkg::N_CTRL, 32'h1);
    poll(0, ulb_pkg::REG_RX_STAT, 8'h01, 8'h01);
    dr(ulb_pkg::REG_RX_DATA, rnd[7:0], 8'hFF);
    // overflow forced by presetting the counter mid measurement, then the abort order
    // writes are doubled since one may meet a counter step and be lost
    poll(1, ulb_pkg::N_STATUS, 8'h01, 8'h00);
    dw(ulb_pkg::REG_DIV_HI, 8'hFF);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h01);
    nw(ulb_pkg::N_TXDATA, 32'h55);
    nw(ulb_pkg::N_CTRL, 32'h1);
    poll(0, ulb_pkg::REG_DIV_HI, 8'hFF, 8'h00);
    repeat (2) dw(ulb_pkg::REG_DIV_HI, 8'hFF);
    repeat (2) dw(ulb_pkg::REG_DIV_LO, 8'hFF);
    poll(0, ulb_pkg::REG_BAUD_CTRL, 8'h81, 8'h81);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h01);
    dr(ulb_pkg::REG_BAUD_CTRL, 8'h81, 8'h81);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h00);
    dw(ulb_pkg::REG_BAUD_CTRL, 8'h00);
    dr(ulb_pkg::REG_BAUD_CTRL, 8'h00, 8'h81);
    tally_and_finish();
  end
endmodule // uart_lin_break_wake_logic_tb
